//--- bench/adc_host_model.sv
// Host model acting as serial master on the chip-select framed link.
module adc_host_model (
  input  wire logic clk_sys,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 1ns;

  // The link idles deselected, with the serial clock standing low.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // Waits for a number of system clock edges.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Sends one frame of n bits, first bit first, with an 800 ns serial clock.
  task automatic frame(input logic [63:0] bits, input int n);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    ticks(4);
    for (int i = n - 1; i >= 0; i--) begin
      din <= bits[i];          // Data settles a half period before the rise.
      ticks(4);
      sclk <= 1'b1;
      ticks(4);
      sclk <= 1'b0;
    end
    ticks(4);
    cs_n <= 1'b1;              // Each frame carries one word or one pattern.
    din  <= ~din;              // A deselected line no longer shows the last bit.
    ticks(8);
  endtask
endmodule // adc_host_model

//--- bench/adc_input_config_sequencer_chk.sv
// Port checker for the converter configuration and sequencer block.
module adc_cfg_chk (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       din,
  input wire logic       conv_done,
  input wire logic [3:0] channel,
  input wire logic       differential,
  input wire logic       twos_complement,
  input wire logic       common_reference,
  input wire logic [3:0] scan_mode,
  input wire logic       sequence_active,
  input wire logic       shutdown_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Common reference mode always converts single input in binary.
  comref_unipolar_a: assert property (common_reference |-> !differential && !twos_complement)
    else $error("common reference with pair or signed coding");
  // Signed coding only ever comes with a pair.
  signed_pair_a: assert property (twos_complement |-> differential)
    else $error("signed coding on a single input");
  // Reset clears every output on the next edge.
  reset_clear_a: assert property (disable iff (1'b0) !reset_n |=> (channel == 4'h0) && !differential
    && !twos_complement && !common_reference && (scan_mode == 4'h0) && !sequence_active && !shutdown_request)
    else $error("outputs not cleared by reset");
  // Mode only changes once a frame has closed.
  mode_hold_a: assert property (!cs_n [*8] |=> $stable(scan_mode))
    else $error("mode changed inside a frame");
  // Shutdown request only changes once a frame has closed.
  shdn_hold_a: assert property (!cs_n [*8] |=> $stable(shutdown_request))
    else $error("shutdown changed inside a frame");
  // A new sequence is switched in while the next frame is open.
  seq_framed_a: assert property ($rose(sequence_active) |-> !cs_n)
    else $error("sequence activated outside a frame");
  // Channel holds inside a frame when no conversion finishes.
  chan_hold_a: assert property ((!cs_n && !conv_done) [*8] |=> $stable(channel))
    else $error("channel moved without cause");
  // Pair arrangement holds inside a frame when no conversion finishes.
  diff_hold_a: assert property ((!cs_n && !conv_done) [*8] |=> $stable(differential))
    else $error("arrangement moved without cause");

  // Main scenarios reached.
  seq_cov: cover property ($rose(sequence_active));
  signed_cov: cover property (twos_complement);
  comref_cov: cover property (common_reference);
endmodule // adc_cfg_chk

bind adc_input_config_sequencer adc_cfg_chk chk (.clk_sys, .reset_n, .cs_n, .sclk, .din, .conv_done, .channel,
  .differential, .twos_complement, .common_reference, .scan_mode, .sequence_active, .shutdown_request);

//--- bench/adc_input_config_sequencer_tb.sv
// Self-checking testbench for the converter configuration and sequencer block.
module adc_input_config_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys, reset_n, conv_done, cs_n, sclk, din;  // Stimulus and link pins.
  logic [3:0] channel, scan_mode;                           // Selected input and mode.
  logic       differential, twos_complement, common_reference, sequence_active, shutdown_request;
  int         num_errors = 0;                               // Mismatches seen.
  int         samples_checked = 0;                          // Comparisons made.

  adc_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .din(din));
  adc_input_config_sequencer uut (.clk_sys(clk_sys), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .din(din),
    .conv_done(conv_done), .channel(channel), .differential(differential), .twos_complement(twos_complement),
    .common_reference(common_reference), .scan_mode(scan_mode), .sequence_active(sequence_active),
    .shutdown_request(shutdown_request));

  // System clock of 100 ns.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Compares one value and counts it.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Writes one configuration word.
  task automatic cfg(input logic [4:0] code, input logic [7:0] field, input logic b2);
    host.frame({48'h0, code, field, b2, 2'h0}, 16);
  endtask

  // Writes one mode word.
  task automatic mode(input logic [3:0] m, input logic [3:0] pick, input logic shdn);
    host.frame({48'h0, 1'b0, m, pick, 3'h0, shdn, 3'h0}, 16);
    host.ticks(4);
  endtask

  // Finishes one conversion and checks the next channel.
  task automatic step(input logic [3:0] exp);
    @(posedge clk_sys);
    conv_done <= 1'b1;
    @(posedge clk_sys);
    conv_done <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(channel, exp);
  endtask

  // All outputs clear after reset.
  task automatic t_reset();
    check({channel, scan_mode}, 8'h00);
    check({differential, twos_complement, common_reference, sequence_active, shutdown_request}, 8'h00);
    $display("test reset done");
  endtask

  // Every row of the coding table, on a different pair each time.
  task automatic t_coding();
    logic [2:0] row [5] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b111};
    logic [2:0] res [5] = '{3'b000, 3'b110, 3'b100, 3'b100, 3'b001};
    logic [3:0] ch;
    for (int r = 0; r < 5; r++) begin
      ch = 4'(r * 3);
      cfg(adc_cfg_pkg::UNIPOLAR_SELECT_CODE, row[r][2] ? (8'h80 >> ch[3:1]) : 8'h00, row[r][1]);
      cfg(adc_cfg_pkg::BIPOLAR_SELECT_CODE, row[r][0] ? (8'h80 >> ch[3:1]) : 8'h00, 1'b0);
      mode(adc_cfg_pkg::MODE_MANUAL, ch, 1'b0);
      check(channel, ch);
      check({differential, twos_complement, common_reference}, res[r]);
      check(scan_mode, adc_cfg_pkg::MODE_MANUAL);
    end
    $display("test coding done");
  endtask

  // A full pattern, then a short one with a broken last identifier over it; wrap at four.
  task automatic t_short();
    cfg(adc_cfg_pkg::SEQUENCE_SELECT_CODE, 8'h03, 1'b0);
    host.frame(64'hFFFF, 16);
    check(sequence_active, 1'b0);
    cfg(adc_cfg_pkg::SEQUENCE_SELECT_CODE, 8'h03, 1'b0);
    host.frame(64'h16A, 10);
    mode(adc_cfg_pkg::MODE_SEQUENCE, 4'h0, 1'b1);
    check(sequence_active, 1'b1);
    check(channel, 4'h5);
    check(shutdown_request, 1'b1);
    step(4'hA);
    step(4'h0);
    step(4'h0);
    step(4'h5);
    $display("test short pattern done");
  endtask

  // Surplus identifiers are dropped with a length of two.
  task automatic t_long();
    // Park the scan on a fixed channel so the reload cannot move it inside a frame.
    mode(adc_cfg_pkg::MODE_MANUAL, 4'h0, 1'b0);
    cfg(adc_cfg_pkg::SEQUENCE_SELECT_CODE, 8'h01, 1'b0);
    host.frame(64'h3C79, 16);
    mode(adc_cfg_pkg::MODE_SEQUENCE, 4'h0, 1'b0);
    check(channel, 4'h3);
    check(shutdown_request, 1'b0);
    step(4'hC);
    step(4'h3);
    $display("test surplus pattern done");
  endtask

  // Custom, standard and upper scans each step through their own channels; repeat stays on its pick.
  task automatic t_custom();
    cfg(adc_cfg_pkg::SCAN_LOW_CODE, 8'h44, 1'b0);
    cfg(adc_cfg_pkg::SCAN_HIGH_CODE, 8'h01, 1'b0);
    mode(adc_cfg_pkg::MODE_CUSTOM, 4'hF, 1'b0);
    check(channel, 4'h2);
    step(4'h6);
    step(4'h8);
    step(4'h2);
    mode(adc_cfg_pkg::MODE_STANDARD, 4'h1, 1'b0);
    check(channel, 4'h0);
    step(4'h1);
    step(4'h0);
    mode(adc_cfg_pkg::MODE_UPPER, 4'hE, 1'b0);
    check(channel, 4'hE);
    step(4'hF);
    step(4'hE);
    mode(adc_cfg_pkg::MODE_REPEAT, 4'h7, 1'b0);
    check(channel, 4'h7);
    step(4'h7);
    $display("test custom scan done");
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial begin
    reset_n   = 1'b0;
    conv_done = 1'b0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_coding();
    t_short();
    t_long();
    t_custom();
    end_of_test();
  end

  // Watchdog: the scenarios need well under 10000 cycles.
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    end_of_test();
  end
endmodule // adc_input_config_sequencer_tb

//--- hw/adc_cfg_pkg.sv
// Shared constants for the converter input configuration and sequencer block.
package adc_cfg_pkg;
  localparam int unsigned WORD_W    = 16;    // Bits in one configuration or mode word.
  localparam int unsigned ID_W      = 4;     // Bits in one channel identifier.
  localparam int unsigned SEQ_DEPTH = 256;   // Largest sequence length.
  localparam int unsigned PAIRS     = 8;     // Number of even/odd input pairs.
  localparam int unsigned CH_N      = 16;    // Number of analog inputs.

  // Word layout shared by every configuration word.
  localparam int unsigned CODE_HI   = 15;    // Top bit of the register select code.
  localparam int unsigned CODE_LO   = 11;    // Bottom bit of the register select code.
  localparam int unsigned FIELD_HI  = 10;    // Top bit of the per-pair or length field.
  localparam int unsigned FIELD_LO  = 3;     // Bottom bit of the per-pair or length field.
  localparam int unsigned COMREF_BIT = 2;    // Position of the common reference mode bit.

  // Register select codes carried in bits 15:11.
  localparam logic [4:0] UNIPOLAR_SELECT_CODE = 5'h11;
  localparam logic [4:0] BIPOLAR_SELECT_CODE  = 5'h12;
  localparam logic [4:0] SCAN_HIGH_CODE       = 5'h14;
  localparam logic [4:0] SCAN_LOW_CODE        = 5'h15;
  localparam logic [4:0] SEQUENCE_SELECT_CODE = 5'h16;

  // Mode control word layout.
  localparam int unsigned MODE_HI   = 14;    // Top bit of the scan mode field.
  localparam int unsigned MODE_LO   = 11;    // Bottom bit of the scan mode field.
  localparam int unsigned PICK_HI   = 10;    // Top bit of the channel pick field.
  localparam int unsigned PICK_LO   = 7;     // Bottom bit of the channel pick field.
  localparam int unsigned SHDN_BIT  = 3;     // Automatic shutdown request bit.

  // Scan mode codes.
  localparam logic [3:0] MODE_NONE     = 4'h0;
  localparam logic [3:0] MODE_MANUAL   = 4'h1;
  localparam logic [3:0] MODE_REPEAT   = 4'h2;
  localparam logic [3:0] MODE_STANDARD = 4'h3;
  localparam logic [3:0] MODE_UPPER    = 4'h5;
  localparam logic [3:0] MODE_CUSTOM   = 4'h7;
  localparam logic [3:0] MODE_SEQUENCE = 4'h9;

  // Reset value and channel limits.
  localparam logic [7:0] PAIRS_RESET = 8'h00;
  localparam logic [3:0] CHANNEL_ZERO = 4'h0;
  localparam logic [3:0] CHANNEL_LAST = 4'hF;
endpackage

//--- hw/adc_input_config_sequencer.sv
// Configuration decoder, channel sequencer and sequence loader of the converter.

// Functional notes
// RQ1 - Coding and arrangement follow unipolar, bipolar registers.
// RQ2 - Pick field or scan bits select channel.
// RQ3 - Sequence holds up to 256 entries.
// RQ4 - Each entry is one 4-bit identifier.
// RQ5 - Host sends length frame, then pattern frame.
// RQ6 - New sequence active by next chip-select fall.
// RQ7 - Missing entries become channel zero.
// RQ8 - Surplus pattern bits ignored until deselect.
// RQ9 - Broken final nibble stores channel zero.
// RQ10 - Mode write starts at first sequence entry.
// RQ11 - Shutdown accepted while reading final result.
// RQ12 - Length change needs a full new pattern.
// RQ13 - All clear single-ended; bipolar only two's complement.
// RQ14 - Pseudo-differential bit overrides the bipolar bit.
// RQ15 - Common reference mode forces unipolar single input.
// RQ16 - Same decision applies to every pair.
// RQ17 - Code 10001 writes the unipolar register.
// RQ18 - Pair bits 10 to 3, default zero.
// RQ19 - Bit 2 enables common reference mode.
// RQ20 - Code 10010 writes the bipolar register.
// RQ21 - Code 10110 sets length, field plus one.
// RQ22 - First bit one configures, zero is mode control.
// RQ23 - Identifiers MSB first, in position order.
// RQ24 - Identifier n selects analog input n.
module adc_input_config_sequencer (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       cs_n,
  input  wire logic       sclk,
  input  wire logic       din,
  input  wire logic       conv_done,
  output logic [3:0]      channel,
  output logic            differential,
  output logic            twos_complement,
  output logic            common_reference,
  output logic [3:0]      scan_mode,
  output logic            sequence_active,
  output logic            shutdown_request
);
  localparam int unsigned CNT_W = $clog2(adc_cfg_pkg::SEQ_DEPTH + 1);  // Width of an entry count.
  localparam int unsigned PTR_W = $clog2(adc_cfg_pkg::SEQ_DEPTH);      // Width of an entry index.

  // All core state in one record.
  typedef struct packed {
    logic [adc_cfg_pkg::SEQ_DEPTH-1:0][adc_cfg_pkg::ID_W-1:0] entries;  // Sequence storage.
    logic [adc_cfg_pkg::WORD_W-1:0] shift;       // Word being received.
    logic [4:0]                     nbits;       // Bits received in this frame, saturating.
    logic                           in_pattern;  // This frame carries identifiers.
    logic [adc_cfg_pkg::ID_W-1:0]   nib;         // Identifier being assembled.
    logic [1:0]                     nib_cnt;     // Bits already in nib.
    logic [CNT_W-1:0]               filled;      // Complete identifiers stored this load.
    logic [CNT_W-1:0]               filled_act;  // Stored identifiers of the active sequence.
    logic [7:0]                     len_staged;  // Length field of the last length word.
    logic [7:0]                     len_act;     // Length field of the active sequence.
    logic                           pattern_due; // Next frame is the pattern frame.
    logic                           activate_due;// Pattern stored, waiting for the next frame.
    logic                           seq_valid;   // A sequence is active.
    logic [7:0]                     uni;         // Pair pseudo-differential bits.
    logic                           comref;      // Common reference mode bit.
    logic [7:0]                     bip;         // Pair bipolar bits.
    logic [adc_cfg_pkg::CH_N-1:0]   scan;        // Per channel scan bits.
    logic [3:0]                     mode;        // Scan mode.
    logic [3:0]                     pick;        // Channel pick field.
    logic                           shdn;        // Automatic shutdown request.
    logic [PTR_W-1:0]               ptr;         // Current scan or sequence position.
    logic [3:0]                     chan;        // Registered selected channel.
    logic                           diff;        // Registered arrangement.
    logic                           twos;        // Registered coding.
    logic                           cref;        // Registered common reference use.
  } core_state_t;

  core_state_t q;  // Registered state.
  core_state_t d;  // Next state.

  frame_bus_if fb ();  // Frame events from the pin receiver.

  logic [3:0] sel_chan;   // Channel chosen from the current position.
  logic       dec_diff;   // Decoded arrangement for sel_chan.
  logic       dec_twos;   // Decoded coding for sel_chan.
  logic       dec_cref;   // Decoded common reference use for sel_chan.

  // Synchronises the pins and turns them into frame events.
  serial_frame_rx u_rx (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .cs_n    (cs_n),
    .sclk    (sclk),
    .din     (din),
    .evt     (fb.source)
  );

  // Decides arrangement and coding for the selected channel.
  pair_coding_decode u_dec (
    .channel          (sel_chan),
    .pseudo_diff_bits (q.uni),
    .bipolar_bits     (q.bip),
    .common_ref       (q.comref),
    .differential     (dec_diff),
    .twos_complement  (dec_twos),
    .against_common   (dec_cref)
  );

  // Returns the next enabled scan channel after cur, wrapping; cur itself if none other.
  function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] r;
    logic [3:0] idx;
    logic       found;
    r     = cur;
    found = 1'b0;
    for (int i = 1; i <= adc_cfg_pkg::CH_N; i++) begin
      idx = cur + 4'(i);
      if (!found && mask[idx]) begin
        r     = idx;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // Returns the sequence entry at a position, zero where no identifier was stored.
  function automatic logic [3:0] entry_at(input core_state_t s, input logic [PTR_W-1:0] p);
    logic [3:0] r;
    r = adc_cfg_pkg::CHANNEL_ZERO;
    if ({1'b0, p} < s.filled_act) begin
      r = s.entries[p];  // [RQ24]
    end
    return r;  // [RQ7] [RQ9]
  endfunction

  // Maps the current position onto a channel for the active mode.
  always_comb begin
    unique case (q.mode)
      adc_cfg_pkg::MODE_MANUAL, adc_cfg_pkg::MODE_REPEAT: begin
        sel_chan = q.pick;  // [RQ2]
      end
      adc_cfg_pkg::MODE_STANDARD, adc_cfg_pkg::MODE_UPPER, adc_cfg_pkg::MODE_CUSTOM: begin
        sel_chan = q.ptr[3:0];  // [RQ2]
      end
      adc_cfg_pkg::MODE_SEQUENCE: begin
        sel_chan = entry_at(q, q.ptr);  // [RQ24]
      end
      default: begin
        sel_chan = q.pick;
      end
    endcase
  end

  // Frame reception, register writes, sequence loading and position stepping.
  always_comb begin
    d = q;

    // Selected channel and its decoded settings follow one cycle later.
    d.chan = sel_chan;
    d.diff = dec_diff;  // [RQ1]
    d.twos = dec_twos;  // [RQ1]
    d.cref = dec_cref;

    // A falling chip select opens the frame and may activate a stored pattern.
    if (fb.frame_start) begin
      d.nbits      = '0;
      d.nib_cnt    = '0;
      d.in_pattern = q.pattern_due;
      if (q.pattern_due) begin
        d.filled = '0;
      end
      if (q.activate_due) begin
        d.len_act      = q.len_staged;  // [RQ6]
        d.filled_act   = q.filled;
        d.seq_valid    = 1'b1;
        d.activate_due = 1'b0;
      end
    end

    // Each serial bit is shifted in most significant first.
    if (fb.bit_valid) begin
      d.shift = {q.shift[adc_cfg_pkg::WORD_W-2:0], fb.bit_value};
      if (q.nbits != 5'(adc_cfg_pkg::WORD_W)) begin
        d.nbits = q.nbits + 5'h01;
      end
      if (q.in_pattern) begin
        // Identifiers assemble MSB first, one per four bits.
        d.nib     = {q.nib[adc_cfg_pkg::ID_W-2:0], fb.bit_value};  // [RQ23] [RQ4]
        d.nib_cnt = q.nib_cnt + 2'h1;
        if (q.nib_cnt == 2'h3) begin
          if (q.filled <= CNT_W'(q.len_staged)) begin
            // Position filled in arrival order.
            d.entries[q.filled[PTR_W-1:0]] = d.nib;  // [RQ23] [RQ3]
            d.filled = q.filled + CNT_W'(1);
          end
          // Identifiers past the length are dropped until deselect.  [RQ8]
        end
      end
    end

    // A rising chip select completes the frame.
    if (fb.frame_end) begin
      if (q.in_pattern) begin
        // A partial nibble is never stored; its position reads as zero.  [RQ9]
        d.in_pattern   = 1'b0;
        d.pattern_due  = 1'b0;
        d.activate_due = 1'b1;
      end else if (q.nbits == 5'(adc_cfg_pkg::WORD_W)) begin
        if (q.shift[adc_cfg_pkg::CODE_HI]) begin
          // Configuration word selected by its code.  [RQ22]
          unique case (q.shift[adc_cfg_pkg::CODE_HI:adc_cfg_pkg::CODE_LO])
            adc_cfg_pkg::UNIPOLAR_SELECT_CODE: begin
              d.uni    = q.shift[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];  // [RQ17] [RQ18]
              d.comref = q.shift[adc_cfg_pkg::COMREF_BIT];                       // [RQ19]
            end
            adc_cfg_pkg::BIPOLAR_SELECT_CODE: begin
              d.bip = q.shift[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];  // [RQ20]
            end
            adc_cfg_pkg::SCAN_HIGH_CODE: begin
              d.scan[15:8] = q.shift[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];
            end
            adc_cfg_pkg::SCAN_LOW_CODE: begin
              d.scan[7:0] = q.shift[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];
            end
            adc_cfg_pkg::SEQUENCE_SELECT_CODE: begin
              // Length word; the next frame must bring the pattern.  [RQ5] [RQ12]
              d.len_staged   = q.shift[adc_cfg_pkg::FIELD_HI:adc_cfg_pkg::FIELD_LO];  // [RQ21]
              d.pattern_due  = 1'b1;
              d.activate_due = 1'b0;
            end
            default: begin
              // Other codes belong to registers outside this block.
            end
          endcase
        end else begin
          // Mode control word restarts the scan at its first position.  [RQ22]
          d.mode = q.shift[adc_cfg_pkg::MODE_HI:adc_cfg_pkg::MODE_LO];
          d.pick = q.shift[adc_cfg_pkg::PICK_HI:adc_cfg_pkg::PICK_LO];
          d.shdn = q.shift[adc_cfg_pkg::SHDN_BIT];  // [RQ11]
          unique case (d.mode)
            adc_cfg_pkg::MODE_UPPER: begin
              d.ptr = PTR_W'(d.pick);
            end
            adc_cfg_pkg::MODE_CUSTOM: begin
              d.ptr = PTR_W'(next_scan(q.scan, adc_cfg_pkg::CHANNEL_LAST));  // [RQ2]
            end
            default: begin
              d.ptr = '0;  // [RQ10]
            end
          endcase
        end
      end
    end

    // A finished conversion steps to the next position of the scan unless a frame ends in the same cycle.
    if (conv_done && !fb.frame_end) begin
      unique case (q.mode)
        adc_cfg_pkg::MODE_STANDARD: begin
          d.ptr = (q.ptr[3:0] == q.pick) ? '0 : q.ptr + PTR_W'(1);
        end
        adc_cfg_pkg::MODE_UPPER: begin
          d.ptr = (q.ptr[3:0] == adc_cfg_pkg::CHANNEL_LAST) ? PTR_W'(q.pick) : q.ptr + PTR_W'(1);
        end
        adc_cfg_pkg::MODE_CUSTOM: begin
          d.ptr = PTR_W'(next_scan(q.scan, q.ptr[3:0]));  // [RQ2]
        end
        adc_cfg_pkg::MODE_SEQUENCE: begin
          // Wraps after entry number length-field, giving field plus one entries.
          d.ptr = (q.ptr == q.len_act) ? '0 : q.ptr + PTR_W'(1);  // [RQ21]
        end
        default: begin
          d.ptr = q.ptr;
        end
      endcase
    end
  end

  // Registers the core state; all pair bits and the length start cleared.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q      <= '0;
      q.uni  <= adc_cfg_pkg::PAIRS_RESET;  // [RQ18]
      q.bip  <= adc_cfg_pkg::PAIRS_RESET;
      q.mode <= adc_cfg_pkg::MODE_NONE;
    end else begin
      q <= d;
    end
  end

  // Outputs come straight from the registered state.
  assign channel          = q.chan;
  assign differential     = q.diff;
  assign twos_complement  = q.twos;
  assign common_reference = q.cref;
  assign scan_mode        = q.mode;
  assign sequence_active  = q.seq_valid;
  assign shutdown_request = q.shdn;
endmodule // adc_input_config_sequencer

//--- hw/frame_bus_if.sv
// Interface carrying framed serial bit events from the pin receiver to the core.
interface frame_bus_if;
  logic frame_start;  // One-cycle pulse on a falling chip select.
  logic frame_end;    // One-cycle pulse on a rising chip select.
  logic bit_valid;    // One-cycle pulse on a rising serial clock inside a frame.
  logic bit_value;    // Data-in level captured with bit_valid.

  // The receiver drives the events.
  modport source (output frame_start, output frame_end, output bit_valid, output bit_value);
  // The core consumes them.
  modport sink (input frame_start, input frame_end, input bit_valid, input bit_value);
endinterface

//--- hw/pair_coding_decode.sv
// Per-channel input arrangement and output coding decision from the pair bits.
module pair_coding_decode (
  input  wire logic [3:0] channel,
  input  wire logic [7:0] pseudo_diff_bits,
  input  wire logic [7:0] bipolar_bits,
  input  wire logic       common_ref,
  output logic            differential,
  output logic            twos_complement,
  output logic            against_common
);
  logic [2:0] pair;      // Pair index of the channel.
  logic       uni_bit;   // Pseudo-differential bit of the pair.
  logic       bip_bit;   // Bipolar bit of the pair.

  // Pair 0 sits in the top bit of each field, pair 7 in the bottom.
  assign pair    = channel[3:1];
  assign uni_bit = pseudo_diff_bits[3'h7 - pair];  // [RQ16]
  assign bip_bit = bipolar_bits[3'h7 - pair];      // [RQ16]

  // Resolves the precedence between the three controlling bits.
  always_comb begin
    if (common_ref) begin
      // Single input against the shared reference, binary.
      differential    = 1'b0;  // [RQ15]
      twos_complement = 1'b0;
      against_common  = 1'b1;
    end else if (uni_bit) begin
      // Unipolar pair wins over the bipolar bit.
      differential    = 1'b1;  // [RQ14]
      twos_complement = 1'b0;
      against_common  = 1'b0;
    end else begin
      // Bipolar pair is two's complement, otherwise single-ended binary.
      differential    = bip_bit;  // [RQ13] [RQ1]
      twos_complement = bip_bit;
      against_common  = 1'b0;
    end
  end
endmodule // pair_coding_decode

//--- hw/serial_frame_rx.sv
// Pin synchroniser and edge finder for the chip-select framed serial link.
module serial_frame_rx (
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  input  wire logic  cs_n,
  input  wire logic  sclk,
  input  wire logic  din,
  frame_bus_if.source evt
);
  // All receiver state in one record.
  typedef struct packed {
    logic [2:0] meta;   // First synchroniser stage of cs_n, sclk, din.
    logic [2:0] sync;   // Second synchroniser stage.
    logic [1:0] prev;   // Previous synchronised cs_n and sclk.
    logic       start;  // Frame start pulse.
    logic       stop;   // Frame end pulse.
    logic       bvalid; // Bit pulse.
    logic       bval;   // Bit value.
  } rx_state_t;

  rx_state_t q;  // Registered state.
  rx_state_t d;  // Next state.

  // Finds chip-select and serial-clock edges on the second stage only.
  always_comb begin
    d        = q;
    d.meta   = {cs_n, sclk, din};
    d.sync   = q.meta;
    d.prev   = q.sync[2:1];
    // Falling chip select opens a frame.
    d.start  = q.prev[1] && !q.sync[2];
    // Rising chip select closes it.
    d.stop   = !q.prev[1] && q.sync[2];
    // Rising serial clock while selected carries one bit.
    d.bvalid = !q.sync[2] && !q.prev[0] && q.sync[1];
    d.bval   = q.sync[0];
  end

  // Registers the state; idle pins read as deselected.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '{meta: 3'h4, sync: 3'h4, prev: 2'h2, default: '0};
    end else begin
      q <= d;
    end
  end

  assign evt.frame_start = q.start;
  assign evt.frame_end   = q.stop;
  assign evt.bit_valid   = q.bvalid;
  assign evt.bit_value   = q.bval;
endmodule // serial_frame_rx
